// ==== src/ttg_pkg.sv ====
/*
  Shared constants and types for the talkback trigger and GPIO block.
  Assumes a single 20 MHz reference clock; all counts derive from it.
*/
`default_nettype none

package ttg_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned HOLD_MS    = 333;
  localparam int unsigned HOLD_CYC   = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_US     = 5000;
  localparam int unsigned DEB_CYC    = DEB_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BLINK_MS   = 250;
  localparam int unsigned BLINK_CYC  = BLINK_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Sizes and reset values
  localparam int unsigned ACT_NUM    = 4;
  localparam int unsigned ACT_IDX_W  = 3;
  localparam int unsigned FN_NUM     = 8;
  localparam logic        SRC_RST    = 1'b0;

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    BTN_MOMENT = 2'h0,
    BTN_LATCH  = 2'h1,
    BTN_AUTO   = 2'h2
  } ttg_btn_mode_t;

  typedef enum logic [1:0] {
    ROUTE_T1   = 2'h1,
    ROUTE_T2   = 2'h2,
    ROUTE_BOTH = 2'h3
  } ttg_route_t;

  typedef enum logic [1:0] {
    IN_PULSE   = 2'h0,
    IN_STATE   = 2'h1,
    IN_INV     = 2'h2
  } ttg_in_mode_t;

  typedef enum logic {
    OUT_ACT_ON  = 1'h0,
    OUT_ACT_OFF = 1'h1
  } ttg_out_mode_t;

  typedef enum logic [2:0] {
    FN_TALK1    = 3'h0,
    FN_TALK2    = 3'h1,
    FN_SUM      = 3'h2,
    FN_MON_CUE  = 3'h3,
    FN_MON_MUTE = 3'h4,
    FN_DOWNMIX  = 3'h5,
    FN_SPK_MUTE = 3'h6,
    FN_SPK_DIM  = 3'h7
  } ttg_fn_t;

  typedef enum logic [1:0] {
    ACT_TOGGLE = 2'h0,
    ACT_ON     = 2'h1,
    ACT_OFF    = 2'h2,
    ACT_TRIG   = 2'h3
  } ttg_act_type_t;

  typedef enum logic [2:0] {
    OP_NOP     = 3'h0,
    OP_CREATE  = 3'h1,
    OP_ENABLE  = 3'h2,
    OP_DISABLE = 3'h3,
    OP_DELETE  = 3'h4
  } ttg_act_op_t;

  // ==========================================================
  // Action table carriers
  typedef struct packed {
    ttg_act_op_t            op;
    logic [ACT_IDX_W-1:0]   idx;
    ttg_act_type_t          typ;
    ttg_fn_t                tgt;
  } ttg_act_cmd_t;

  typedef struct packed {
    logic                   valid;
    logic                   en;
    ttg_act_type_t          typ;
    ttg_fn_t                tgt;
  } ttg_act_ent_t;

endpackage

`default_nettype wire

// ==== src/ttg_debounce.sv ====
/*
  Two-flop synchroniser followed by a stability counter.
  Assumes the raw input may bounce; a level is accepted only after it
  has stood for CYCLES clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module ttg_debounce #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_raw,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  import ttg_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          stable;
    logic          rise;
    logic          fall;
    logic [CW-1:0] cnt;
  } ttg_deb_st_t;

  ttg_deb_st_t st_q;
  ttg_deb_st_t st_d;

  // ==========================================================
  // Filter
  always_comb
  begin
    st_d      = st_q;
    st_d.s1   = i_raw;
    st_d.s2   = st_q.s1;
    st_d.rise = 1'b0;
    st_d.fall = 1'b0;
    // Only the second stage is looked at; the first may be metastable
    if (st_q.s2 != st_q.stable)
    begin
      if (st_q.cnt == CW'(CYCLES - 1))
      begin
        st_d.stable = st_q.s2;
        st_d.rise   = st_q.s2;
        st_d.fall   = ~st_q.s2;
        st_d.cnt    = '0;
      end
      else
      begin
        st_d.cnt = st_q.cnt + CW'(1);
      end
    end
    else
    begin
      st_d.cnt = '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_level = st_q.stable;
  assign o_rise  = st_q.rise;
  assign o_fall  = st_q.fall;

endmodule

`default_nettype wire

// ==== src/ttg_talkback_trigger_gpio.sv ====
/*
  Talkback button and rear footswitch/indicator trigger logic.
  Assumes all inputs synchronous-capable plain levels, config ports held
  stable by the controlling software, and one 20 MHz reference clock.
*/
// Overview of operation
// - Source is MIDI or GPIO; MIDI after reset
// - Momentary mode: talk only while button held
// - Latching mode: each press toggles talk
// - Auto mode: long hold momentary, short latches
// - Talk engaged blinks the button indicator
// - Button routes to talk 1, 2 or both
// - Footswitch and indicator work only under GPIO
// - Pulse mode fires on closed-to-open edge
// - State mode fires on open; toggles follow open
// - Inverted mode fires on close; toggles follow closed
// - New actions start enabled; disable or delete later
// - Toggle flips, on sets, off clears target
// - Trigger actions pulse every time, keep no state
// - Monitor mute on speaker-set monitor does nothing
// - Active-on output conducts while condition true
// - Active-off output conducts while condition false
`timescale 1ns/1ps
`default_nettype none

module ttg_talkback_trigger_gpio #(
  parameter int unsigned HOLD_CYCLES  = ttg_pkg::HOLD_CYC,
  parameter int unsigned DEB_CYCLES   = ttg_pkg::DEB_CYC,
  parameter int unsigned BLINK_CYCLES = ttg_pkg::BLINK_CYC,
  parameter int unsigned NUM_ACT      = ttg_pkg::ACT_NUM
) (
  input  wire logic                     I_REF_CLK,
  input  wire logic                     I_SYS_RST,
  input  wire logic                     I_SRC_GPIO,
  input  wire ttg_pkg::ttg_btn_mode_t   I_BTN_MODE,
  input  wire ttg_pkg::ttg_route_t      I_BTN_ROUTE,
  input  wire logic                     I_TALK_BTN,
  input  wire logic                     I_FOOTSWITCH_INPUT,
  input  wire ttg_pkg::ttg_in_mode_t    I_IN_MODE,
  input  wire ttg_pkg::ttg_act_cmd_t    I_ACT_CMD,
  input  wire logic                     I_MON_IS_SPKSET,
  input  wire ttg_pkg::ttg_fn_t         I_OUT_SEL,
  input  wire ttg_pkg::ttg_out_mode_t   I_OUT_MODE,
  output logic                          O_SRC_GPIO,
  output logic [1:0]                    O_TALK,
  output logic                          O_TALK_LED,
  output logic [ttg_pkg::FN_NUM-1:0]    O_FN_STATE,
  output logic [ttg_pkg::FN_NUM-1:0]    O_FN_TRIG,
  output logic                          O_INDICATOR_OUTPUT,
  output logic [NUM_ACT-1:0]            O_ACT_VALID,
  output logic [NUM_ACT-1:0]            O_ACT_EN
);
  import ttg_pkg::*;

  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned BW = $clog2(BLINK_CYCLES + 1);

  typedef enum logic [1:0] {
    TALK_OFF   = 2'h0,
    TALK_PRESS = 2'h1,
    TALK_HOLD  = 2'h2,
    TALK_LATCH = 2'h3
  } ttg_talk_st_t;

  typedef struct packed {
    logic                       src_gpio;
    ttg_talk_st_t               talk_st;
    logic [HW-1:0]              hold_cnt;
    logic [BW-1:0]              blink_cnt;
    logic                       blink_ph;
    logic [1:0]                 talk;
    logic                       led;
    logic [FN_NUM-1:0]          fn;
    logic [FN_NUM-1:0]          trig;
    logic                       ind;
    ttg_act_ent_t [NUM_ACT-1:0] act;
  } ttg_st_t;

  localparam ttg_st_t ST_RST = '{
    src_gpio: SRC_RST,
    talk_st:  TALK_OFF,
    default:  '0
  };

  ttg_st_t st_q;
  ttg_st_t st_d;

  // ==========================================================
  // Input conditioning
  logic btn_lvl;
  logic btn_rise;
  logic btn_fall;
  logic fsw_closed;
  logic fsw_close;
  logic fsw_open;

  // Contact bounce would otherwise toggle latches several times
  ttg_debounce #(
    .CYCLES (DEB_CYCLES)
  ) u_btn_deb (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_raw   (I_TALK_BTN),
    .o_level (btn_lvl),
    .o_rise  (btn_rise),
    .o_fall  (btn_fall)
  );

  ttg_debounce #(
    .CYCLES (DEB_CYCLES)
  ) u_fsw_deb (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_raw   (I_FOOTSWITCH_INPUT),
    .o_level (fsw_closed),
    .o_rise  (fsw_close),
    .o_fall  (fsw_open)
  );

  // ==========================================================
  // Footswitch event decode
  logic fsw_event;
  logic fsw_follow;
  logic fsw_on;

  always_comb
  begin
    unique case (I_IN_MODE)
      IN_PULSE:
      begin
        fsw_event  = fsw_open;
        fsw_follow = 1'b0;
        fsw_on     = 1'b0;
      end
      IN_STATE:
      begin
        fsw_event  = fsw_open;
        fsw_follow = fsw_open | fsw_close;
        fsw_on     = ~fsw_closed;
      end
      IN_INV:
      begin
        fsw_event  = fsw_close;
        fsw_follow = fsw_open | fsw_close;
        fsw_on     = fsw_closed;
      end
      default:
      begin
        fsw_event  = 1'b0;
        fsw_follow = 1'b0;
        fsw_on     = 1'b0;
      end
    endcase
  end

  logic [1:0] route;
  logic       btn_on;
  logic       ind_cond;

  assign route  = I_BTN_ROUTE;
  assign btn_on = (st_q.talk_st != TALK_OFF);

  // ==========================================================
  // Next state
  always_comb
  begin
    st_d      = st_q;
    st_d.trig = '0;
    ind_cond  = 1'b0;

    // Selection is registered so it comes up MIDI regardless of the pin
    st_d.src_gpio = I_SRC_GPIO;

    // Talk button state machine
    unique case (st_q.talk_st)
      TALK_OFF:
      begin
        st_d.hold_cnt = '0;
        if (btn_rise)
        begin
          unique case (I_BTN_MODE)
            BTN_MOMENT: st_d.talk_st = TALK_HOLD;
            BTN_LATCH:  st_d.talk_st = TALK_LATCH;
            default:    st_d.talk_st = TALK_PRESS;
          endcase
        end
      end
      TALK_PRESS:
      begin
        if (btn_fall)
          st_d.talk_st = TALK_LATCH;
        else if (st_q.hold_cnt == HW'(HOLD_CYCLES - 1))
          st_d.talk_st = TALK_HOLD;
        else
          st_d.hold_cnt = st_q.hold_cnt + HW'(1);
      end
      TALK_HOLD:
      begin
        if (!btn_lvl)
          st_d.talk_st = TALK_OFF;
      end
      TALK_LATCH:
      begin
        if (btn_rise)
          st_d.talk_st = TALK_OFF;
      end
    endcase

    // Action table maintenance, only reachable in GPIO mode
    if (st_q.src_gpio && (32'(I_ACT_CMD.idx) < NUM_ACT))
    begin
      unique case (I_ACT_CMD.op)
        OP_NOP:
        begin
        end
        OP_CREATE:
        begin
          st_d.act[I_ACT_CMD.idx].valid = 1'b1;
          st_d.act[I_ACT_CMD.idx].en    = 1'b1;
          st_d.act[I_ACT_CMD.idx].typ   = I_ACT_CMD.typ;
          st_d.act[I_ACT_CMD.idx].tgt   = I_ACT_CMD.tgt;
        end
        OP_ENABLE:
        begin
          if (st_q.act[I_ACT_CMD.idx].valid)
            st_d.act[I_ACT_CMD.idx].en = 1'b1;
        end
        OP_DISABLE:
        begin
          st_d.act[I_ACT_CMD.idx].en = 1'b0;
        end
        OP_DELETE:
        begin
          st_d.act[I_ACT_CMD.idx] = '0;
        end
        default:
        begin
        end
      endcase
    end

    // Apply footswitch actions; entries act in index order on one event
    if (st_q.src_gpio)
    begin
      for (int k = 0; k < NUM_ACT; k++)
      begin
        if (st_q.act[k].valid && st_q.act[k].en &&
            !(st_q.act[k].tgt == FN_MON_MUTE && I_MON_IS_SPKSET))
        begin
          unique case (st_q.act[k].typ)
            ACT_TOGGLE:
            begin
              if (fsw_follow)
                st_d.fn[st_q.act[k].tgt] = fsw_on;
              else if (fsw_event)
                st_d.fn[st_q.act[k].tgt] = ~st_d.fn[st_q.act[k].tgt];
            end
            ACT_ON:
            begin
              if (fsw_event)
                st_d.fn[st_q.act[k].tgt] = 1'b1;
            end
            ACT_OFF:
            begin
              if (fsw_event)
                st_d.fn[st_q.act[k].tgt] = 1'b0;
            end
            ACT_TRIG:
            begin
              if (fsw_event)
                st_d.trig[st_q.act[k].tgt] = 1'b1;
            end
          endcase
        end
      end
    end

    // Button and footswitch talk requests merge per channel
    st_d.talk[0] = (btn_on & route[0]) | st_d.fn[FN_TALK1];
    st_d.talk[1] = (btn_on & route[1]) | st_d.fn[FN_TALK2];

    // Indicator blinks from a phase counter that restarts per engage
    if (|st_d.talk)
    begin
      if (st_q.blink_cnt == BW'(BLINK_CYCLES - 1))
      begin
        st_d.blink_cnt = '0;
        st_d.blink_ph  = ~st_q.blink_ph;
      end
      else
      begin
        st_d.blink_cnt = st_q.blink_cnt + BW'(1);
      end
    end
    else
    begin
      st_d.blink_cnt = '0;
      st_d.blink_ph  = 1'b0;
    end
    st_d.led = (|st_d.talk) & ~st_d.blink_ph;

    // Indicator condition uses the effective talk state
    if (I_OUT_SEL == FN_TALK1)
      ind_cond = st_d.talk[0];
    else if (I_OUT_SEL == FN_TALK2)
      ind_cond = st_d.talk[1];
    else
      ind_cond = st_d.fn[I_OUT_SEL];

    // Transistor stays off in MIDI mode whatever the polarity
    if (!st_d.src_gpio)
      st_d.ind = 1'b0;
    else if (I_OUT_MODE == OUT_ACT_ON)
      st_d.ind = ind_cond;
    else
      st_d.ind = ~ind_cond;
  end

  // ==========================================================
  // State register
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  // ==========================================================
  // Outputs
  assign O_SRC_GPIO         = st_q.src_gpio;
  assign O_TALK             = st_q.talk;
  assign O_TALK_LED         = st_q.led;
  assign O_FN_STATE         = st_q.fn;
  assign O_FN_TRIG          = st_q.trig;
  assign O_INDICATOR_OUTPUT = st_q.ind;

  always_comb
  begin
    for (int k = 0; k < NUM_ACT; k++)
    begin
      O_ACT_VALID[k] = st_q.act[k].valid;
      O_ACT_EN[k]    = st_q.act[k].en;
    end
  end

endmodule

`default_nettype wire

// ==== dv/ttg_checker.sv ====
/*
  Port-level assertions for the talkback trigger block.
  Assumes short counts from the bench and bind to every top instance.
*/
`timescale 1ns/1ps
`default_nettype none

module ttg_checker
  import ttg_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = 8,
  parameter int unsigned NUM_ACT      = 4
) (
  input wire logic                I_REF_CLK,
  input wire logic                I_SYS_RST,
  input wire logic                I_SRC_GPIO,
  input wire ttg_act_cmd_t        I_ACT_CMD,
  input wire logic                I_MON_IS_SPKSET,
  input wire ttg_fn_t             I_OUT_SEL,
  input wire ttg_out_mode_t       I_OUT_MODE,
  input wire logic                O_SRC_GPIO,
  input wire logic [1:0]          O_TALK,
  input wire logic                O_TALK_LED,
  input wire logic [FN_NUM-1:0]   O_FN_STATE,
  input wire logic [FN_NUM-1:0]   O_FN_TRIG,
  input wire logic                O_INDICATOR_OUTPUT,
  input wire logic [NUM_ACT-1:0]  O_ACT_VALID,
  input wire logic [NUM_ACT-1:0]  O_ACT_EN
);
  logic [31:0] run_q;
  logic        led_q;
  logic [2:0]  idx_q;
  logic        cond;

  // ==========================================================
  // Helpers
  assign cond = (I_OUT_SEL == FN_TALK1 || I_OUT_SEL == FN_TALK2) ?
                O_TALK[I_OUT_SEL[0]] : O_FN_STATE[I_OUT_SEL];

  // Counts how long the lamp stands while talking; a frozen lamp overflows it
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      run_q <= 32'h0;
      led_q <= 1'b0;
      idx_q <= 3'h0;
    end
    else
    begin
      run_q <= ((|O_TALK) && O_TALK_LED == led_q) ? run_q + 32'h1 : 32'h0;
      led_q <= O_TALK_LED;
      idx_q <= I_ACT_CMD.idx;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_src_follow: assert property (
    !$past(I_SYS_RST) |-> O_SRC_GPIO == $past(I_SRC_GPIO))
    else $error("source select did not follow its input");
  a_midi_dark: assert property (
    !O_SRC_GPIO && !$past(O_SRC_GPIO) |-> !O_INDICATOR_OUTPUT)
    else $error("indicator driven in MIDI mode");
  a_midi_freeze: assert property (
    !O_SRC_GPIO && !$past(O_SRC_GPIO) && !$past(O_SRC_GPIO, 2) |-> $stable(O_FN_STATE))
    else $error("function state moved in MIDI mode");
  a_cmd_refuse: assert property (
    !O_SRC_GPIO |=> $stable(O_ACT_VALID) && $stable(O_ACT_EN))
    else $error("action table changed in MIDI mode");
  a_create_enabled: assert property (
    I_ACT_CMD.op == OP_CREATE && O_SRC_GPIO && I_ACT_CMD.idx < NUM_ACT
    |=> O_ACT_VALID[idx_q] && O_ACT_EN[idx_q])
    else $error("created entry not valid and enabled");
  a_disable_clear: assert property (
    I_ACT_CMD.op == OP_DISABLE && O_SRC_GPIO && I_ACT_CMD.idx < NUM_ACT
    |=> !O_ACT_EN[idx_q])
    else $error("disabled entry still enabled");
  a_trig_single: assert property (|O_FN_TRIG |=> O_FN_TRIG == '0)
    else $error("trigger pulse longer than one cycle");
  a_mute_block: assert property (
    I_MON_IS_SPKSET && $past(I_MON_IS_SPKSET) |-> $stable(O_FN_STATE[FN_MON_MUTE]))
    else $error("monitor mute moved on a speaker set");
  a_ind_on: assert property (
    O_SRC_GPIO && $past(O_SRC_GPIO) && $stable(I_OUT_SEL) && $stable(I_OUT_MODE)
    && I_OUT_MODE == OUT_ACT_ON |-> O_INDICATOR_OUTPUT == cond)
    else $error("active-on indicator wrong");
  a_ind_off: assert property (
    O_SRC_GPIO && $past(O_SRC_GPIO) && $stable(I_OUT_SEL) && $stable(I_OUT_MODE)
    && I_OUT_MODE == OUT_ACT_OFF |-> O_INDICATOR_OUTPUT == !cond)
    else $error("active-off indicator wrong");
  a_led_dark: assert property (~|O_TALK |-> !O_TALK_LED)
    else $error("talk lamp lit without talk");
  a_blink_rate: assert property (run_q <= BLINK_CYCLES)
    else $error("talk lamp not blinking");

  c_talk_both: cover property (O_TALK == 2'h3);
  c_trig_seen: cover property (|O_FN_TRIG);
  c_ind_on:    cover property (O_INDICATOR_OUTPUT);
endmodule

bind ttg_talkback_trigger_gpio ttg_checker #(
  .BLINK_CYCLES(BLINK_CYCLES), .NUM_ACT(NUM_ACT)) ttg_checker_i (
  .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_SRC_GPIO(I_SRC_GPIO),
  .I_ACT_CMD(I_ACT_CMD), .I_MON_IS_SPKSET(I_MON_IS_SPKSET), .I_OUT_SEL(I_OUT_SEL),
  .I_OUT_MODE(I_OUT_MODE), .O_SRC_GPIO(O_SRC_GPIO), .O_TALK(O_TALK),
  .O_TALK_LED(O_TALK_LED), .O_FN_STATE(O_FN_STATE), .O_FN_TRIG(O_FN_TRIG),
  .O_INDICATOR_OUTPUT(O_INDICATOR_OUTPUT), .O_ACT_VALID(O_ACT_VALID),
  .O_ACT_EN(O_ACT_EN));

`default_nettype wire

// ==== dv/ttg_switch_model.sv ====
/*
  Bouncing contact model for the talk button or the footswitch.
  Assumes the bench changes i_want with non-blocking assignment.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Contact model
module ttg_switch_model (
  input  wire logic i_clk,
  input  wire logic i_want,
  output logic      o_raw
);
  logic [1:0] cnt_q;
  logic       last_q;

  initial
  begin
    cnt_q  = 2'h0;
    last_q = 1'b0;
    o_raw  = 1'b0;
  end

  // Chatter pulses stay shorter than the debounce window
  always @(negedge i_clk)
  begin
    if (i_want != last_q)
    begin
      cnt_q  <= 2'h3;
      last_q <= i_want;
      o_raw  <= ~o_raw;
    end
    else if (cnt_q != 2'h0)
    begin
      cnt_q <= cnt_q - 2'h1;
      o_raw <= ~o_raw;
    end
    else
      o_raw <= last_q;
  end
endmodule

`default_nettype wire

// ==== dv/ttg_talkback_trigger_gpio_bench.sv ====
/*
  Self-checking bench: button modes, routing, footswitch modes, actions.
  Assumes short counts: hold 40, debounce 4, blink 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module ttg_talkback_trigger_gpio_bench
  import ttg_pkg::*;
;
  logic          clk, rst, src, spk, b, f, src_o, led, ind, l;
  ttg_btn_mode_t bm;
  ttg_route_t    rt;
  ttg_in_mode_t  im;
  ttg_act_cmd_t  cmd;
  ttg_fn_t       os;
  ttg_out_mode_t om;
  logic          b_raw, f_raw;
  logic [1:0]    talk;
  logic [7:0]    fn, trig;
  logic [3:0]    av, ae;
  int            error_cnt, n_checks, cyc_n, trig_n, k;

  ttg_switch_model btn_model_i (.i_clk(clk), .i_want(b), .o_raw(b_raw));
  ttg_switch_model fsw_model_i (.i_clk(clk), .i_want(f), .o_raw(f_raw));

  ttg_talkback_trigger_gpio #(.HOLD_CYCLES(40), .DEB_CYCLES(4), .BLINK_CYCLES(8),
    .NUM_ACT(4)) ttg_talkback_trigger_gpio_i (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_SRC_GPIO(src), .I_BTN_MODE(bm),
    .I_BTN_ROUTE(rt), .I_TALK_BTN(b_raw), .I_FOOTSWITCH_INPUT(f_raw),
    .I_IN_MODE(im), .I_ACT_CMD(cmd), .I_MON_IS_SPKSET(spk), .I_OUT_SEL(os),
    .I_OUT_MODE(om), .O_SRC_GPIO(src_o), .O_TALK(talk), .O_TALK_LED(led),
    .O_FN_STATE(fn), .O_FN_TRIG(trig), .O_INDICATOR_OUTPUT(ind),
    .O_ACT_VALID(av), .O_ACT_EN(ae));

  // ==========================================================
  // Clock, timeout and tasks
  always #25 clk = ~clk;

  // Counted mid-cycle so a one-cycle pulse is seen once, away from its edge
  always @(negedge clk)
  begin
    cyc_n++;
    if (trig[FN_SPK_DIM])
      trig_n++;
    if (cyc_n == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Settle time covers chatter, synchroniser and debounce
  task automatic press(input logic v);
    b <= v;
    cyc(14);
  endtask

  task automatic fsw(input logic v);
    f <= v;
    cyc(14);
  endtask

  task automatic act(input ttg_act_op_t op, input logic [2:0] i, input ttg_act_type_t t,
                     input ttg_fn_t g);
    cmd = '{op, i, t, g};
    cyc(1);
    cmd.op = OP_NOP;
    cyc(1);
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    clk = 1'b0; rst = 1'b1; src = 1'b0; spk = 1'b0; b = 1'b0; f = 1'b0;
    bm = BTN_MOMENT; rt = ROUTE_T1; im = IN_PULSE; cmd = '0;
    os = FN_SUM; om = OUT_ACT_ON;
    error_cnt = 0; n_checks = 0; cyc_n = 0; trig_n = 0;
    cyc(3);
    rst = 1'b0;
    cyc(2);
    chk(src_o, 1'b0);
    for (int r = 1; r < 4; r++)
    begin
      rt = ttg_route_t'(r);
      press(1'b1);
      chk(talk, r);
      press(1'b0);
      chk(talk, 2'h0);
    end
    press(1'b1);
    l = led;
    k = 0;
    repeat (20)
    begin
      cyc(1);
      k += (led != l);
      l = led;
    end
    chk(k >= 2, 1'b1);
    press(1'b0);
    $display("test momentary done");
    bm = BTN_LATCH;
    rt = ROUTE_T1;
    for (int i = 0; i < 2; i++)
    begin
      press(1'b1);
      press(1'b0);
      chk(talk, i ? 2'h0 : 2'h1);
    end
    bm = BTN_AUTO;
    rt = ROUTE_BOTH;
    press(1'b1);
    press(1'b0);
    chk(talk, 2'h3);
    press(1'b1);
    press(1'b0);
    chk(talk, 2'h0);
    press(1'b1);
    cyc(50);
    chk(talk, 2'h3);
    press(1'b0);
    chk(talk, 2'h0);
    $display("test latch modes done");
    act(OP_CREATE, 3'h0, ACT_TOGGLE, FN_SUM);
    chk(av, 4'h0);
    src = 1'b1;
    cyc(2);
    chk(src_o, 1'b1);
    act(OP_CREATE, 3'h0, ACT_TOGGLE, FN_SUM);
    chk({av, ae}, 8'h11);
    fsw(1'b1);
    chk(fn[FN_SUM], 1'b0);
    fsw(1'b0);
    chk(fn[FN_SUM], 1'b1);
    chk(ind, 1'b1);
    om = OUT_ACT_OFF;
    cyc(3);
    chk(ind, 1'b0);
    om = OUT_ACT_ON;
    f <= 1'b1;
    cyc(1);
    f <= 1'b0;
    cyc(14);
    chk(fn[FN_SUM], 1'b1);
    act(OP_DISABLE, 3'h0, ACT_TOGGLE, FN_SUM);
    chk(ae, 4'h0);
    fsw(1'b1);
    fsw(1'b0);
    chk(fn[FN_SUM], 1'b1);
    act(OP_ENABLE, 3'h0, ACT_TOGGLE, FN_SUM);
    chk(ae, 4'h1);
    act(OP_DELETE, 3'h0, ACT_TOGGLE, FN_SUM);
    chk(av, 4'h0);
    $display("test pulse done");
    for (int t = 0; t < 3; t++)
    begin
      act(OP_CREATE, 3'h1, ttg_act_type_t'((t + 1) % 3), FN_DOWNMIX);
      fsw(1'b1);
      fsw(1'b0);
      chk(fn[FN_DOWNMIX], t != 1);
      act(OP_DELETE, 3'h1, ACT_TOGGLE, FN_DOWNMIX);
    end
    act(OP_CREATE, 3'h2, ACT_TRIG, FN_SPK_DIM);
    for (int i = 1; i < 3; i++)
    begin
      fsw(1'b1);
      fsw(1'b0);
      chk(trig_n, i);
    end
    chk(fn[FN_SPK_DIM], 1'b0);
    act(OP_DELETE, 3'h2, ACT_TRIG, FN_SPK_DIM);
    spk = 1'b1;
    act(OP_CREATE, 3'h3, ACT_ON, FN_MON_MUTE);
    fsw(1'b1);
    fsw(1'b0);
    chk(fn[FN_MON_MUTE], 1'b0);
    spk = 1'b0;
    fsw(1'b1);
    fsw(1'b0);
    chk(fn[FN_MON_MUTE], 1'b1);
    $display("test action types done");
    act(OP_CREATE, 3'h0, ACT_TOGGLE, FN_SUM);
    im = IN_STATE;
    fsw(1'b1);
    chk(fn[FN_SUM], 1'b0);
    fsw(1'b0);
    chk(fn[FN_SUM], 1'b1);
    im = IN_INV;
    fsw(1'b1);
    chk(fn[FN_SUM], 1'b1);
    fsw(1'b0);
    chk(fn[FN_SUM], 1'b0);
    $display("test state modes done");
    wrap_up();
  end
endmodule

`default_nettype wire
